// ---- ccr_map.svh ----
// Register offsets, field positions and reset values of the calibration control bank
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CCR_OFS_AVERAGING    8'h68
`define CCR_OFS_STATUS       8'h6A
`define CCR_OFS_PIN_CONFIG   8'h6B
`define CCR_OFS_SOFT_TRIG    8'h6C
`define CCR_OFS_LOW_POWER    8'h6E
`define CCR_OFS_IRQ_STATUS   8'h78
`define CCR_OFS_IRQ_MASK     8'h79

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CCR_OFFSET_AVERAGING_LSB       4
`define CCR_LIN_AVG_LSB      0
`define CCR_STAT_CODE_LSB    2
`define CCR_HALTED_BIT       1
`define CCR_FOREGROUND_DONE_BIT      0
`define CCR_SEL_LSB          1
`define CCR_TRIG_SRC_BIT     0
`define CCR_SOFT_TRIG_BIT    0
`define CCR_LP_EN_BIT        0
`define CCR_LOWPOWER_TRIGGER_MODE_BIT      1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CCR_RST_OFFSET_AVERAGING       3'h6
`define CCR_RST_LIN_AVG      3'h1
`define CCR_RST_PIN_CONFIG   8'h00
`define CCR_RST_SOFT_TRIG    8'h01
`define CCR_RST_LOW_POWER    8'h88
`define CCR_RST_IRQ_MASK     4'h0

`endif

// ---- ccr_pkg.sv ----
// Types shared by the calibration control bank
package ccr_pkg;

  // Status pin source select
  typedef enum logic [1:0] {
    CCR_SEL_FOREGROUND_DONE = 2'h0,
    CCR_SEL_HALTED  = 2'h1,
    CCR_SEL_ALARM   = 2'h2,
    CCR_SEL_LOW     = 2'h3
  } ccr_sel_e;

  // Status reported by the calibration engine
  typedef struct packed {
    logic [2:0] code;
    logic       foreground_done;
    logic       bg_stopped;
    logic       bg_resumed;
    logic       bg_enabled;
    logic       alarm;
  } ccr_engine_s;

  // Settings handed to the calibration engine
  typedef struct packed {
    logic [2:0] offset_averaging;
    logic [2:0] linearity_averaging;
    logic       lp_enable;
    logic       lowpower_trigger_mode;
  } ccr_settings_s;

endpackage

// ---- ccr_trig_sel.sv ----
// Calibration trigger source selection and low-power wake request
`timescale 1ns/1ns
module ccr_trig_sel
  import ccr_pkg::*;
(
  input  wire logic mclk_i,          // Clock
  input  wire logic rst_n_i,         // Synced reset, active low
  input  wire logic trig_src_i,      // Trigger source select
  input  wire logic soft_trig_i,     // Software trigger bit
  input  wire logic hw_trig_i,       // Hardware trigger pin
  input  wire logic lp_enable_i,     // Low-power calibration on
  input  wire logic lowpower_trigger_mode_mode_i,  // Trigger-driven sleep mode
  output logic      trigger_o,       // Selected trigger level
  output logic      wake_o           // Wake request to core
);

  logic trig_next;

  // Trigger mux
  // hardware source when trig_src_i is set, else software
  always_comb begin
    trig_next = trig_src_i ? hw_trig_i : soft_trig_i;
  end

  // Registered trigger
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trigger_o <= 1'b1;
    end else begin
      trigger_o <= trig_next;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= lp_enable_i & lowpower_trigger_mode_mode_i & ~trig_next;
    end
  end

endmodule

// ---- ccr_regs.sv ----
// Calibration control and status register bank
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
`include "ccr_map.svh"
module ccr_regs
  import ccr_pkg::*;
(
  input  wire logic          mclk_i,       // Clock, 125 MHz
  input  wire logic          rst_b_i,      // Async reset, active low
  input  wire logic [7:0]    addr_i,       // Register address
  input  wire logic [7:0]    wdata_i,      // Write data
  input  wire logic          wr_i,         // Write strobe
  input  wire logic          rd_i,         // Read strobe
  output logic      [7:0]    rdata_o,      // Read data, next cycle
  input  wire ccr_engine_s   engine_i,     // Engine status
  input  wire logic          hw_trig_i,    // Hardware trigger pin
  output logic               status_pin_o, // Status output pin
  output logic               trigger_o,    // Selected calibration trigger
  output logic               wake_o,       // Wake request to sleeping core
  output ccr_settings_s      settings_o,   // Settings to engine
  output logic               irq_o         // Interrupt, active high
);

  // ----------------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;

  // Release reset through two flops
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  logic wr_avg;
  logic wr_pin;
  logic wr_soft;
  logic wr_lp;
  logic wr_irq_stat;
  logic wr_irq_mask;

  // Address strobes
  assign wr_avg      = wr_i & hit(addr_i, `CCR_OFS_AVERAGING);
  assign wr_pin      = wr_i & hit(addr_i, `CCR_OFS_PIN_CONFIG);
  assign wr_soft     = wr_i & hit(addr_i, `CCR_OFS_SOFT_TRIG);
  assign wr_lp       = wr_i & hit(addr_i, `CCR_OFS_LOW_POWER);
  assign wr_irq_stat = wr_i & hit(addr_i, `CCR_OFS_IRQ_STATUS);
  assign wr_irq_mask = wr_i & hit(addr_i, `CCR_OFS_IRQ_MASK);

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic [2:0] offset_averaging_reg;
  logic [2:0] lin_avg_reg;
  logic [2:0] pin_cfg_reg;
  logic       soft_trig_reg;
  logic [7:0] lp_reg;

  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      offset_averaging_reg  <= `CCR_RST_OFFSET_AVERAGING;
      lin_avg_reg <= `CCR_RST_LIN_AVG;
    end else if (wr_avg) begin
      offset_averaging_reg  <= wdata_i[`CCR_OFFSET_AVERAGING_LSB +: 3];
      lin_avg_reg <= wdata_i[`CCR_LIN_AVG_LSB +: 3];
    end
  end

  // Pin configuration, select and source
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pin_cfg_reg <= 3'(`CCR_RST_PIN_CONFIG);
    end else if (wr_pin) begin
      pin_cfg_reg <= wdata_i[2:0];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      soft_trig_reg <= 1'(`CCR_RST_SOFT_TRIG);
    end else if (wr_soft) begin
      soft_trig_reg <= wdata_i[`CCR_SOFT_TRIG_BIT];
    end
  end

  // Low-power calibration register
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      lp_reg <= `CCR_RST_LOW_POWER;
    end else if (wr_lp) begin
      lp_reg <= wdata_i;
    end
  end

  // Settings to the engine
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      settings_o <= '0;
    end else begin
      settings_o.offset_averaging      <= offset_averaging_reg;
      settings_o.linearity_averaging   <= lin_avg_reg;
      settings_o.lp_enable             <= lp_reg[`CCR_LP_EN_BIT];
      settings_o.lowpower_trigger_mode <= lp_reg[`CCR_LOWPOWER_TRIGGER_MODE_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Calibration status
  // ----------------------------------------------------------------------
  logic       foreground_done_reg;
  logic       halted_reg;
  logic [2:0] code_reg;

  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      code_reg <= 3'h0;
    end else begin
      code_reg <= engine_i.code;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      foreground_done_reg <= 1'b0;
    end else begin
      foreground_done_reg <= engine_i.foreground_done;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      halted_reg <= 1'b0;
    end else if (engine_i.bg_stopped) begin
      halted_reg <= 1'b1;
    end else if (!engine_i.bg_enabled && engine_i.foreground_done) begin
      halted_reg <= 1'b1;
    end else if (engine_i.bg_resumed) begin
      halted_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Status pin and trigger
  // ----------------------------------------------------------------------
  ccr_sel_e sel;
  logic     pin_next;

  assign sel = ccr_sel_e'(pin_cfg_reg[`CCR_SEL_LSB +: 2]);

  always_comb begin
    unique case (sel)
      CCR_SEL_FOREGROUND_DONE: pin_next = foreground_done_reg;
      CCR_SEL_HALTED:  pin_next = halted_reg;
      CCR_SEL_ALARM:   pin_next = engine_i.alarm;
      CCR_SEL_LOW:     pin_next = 1'b0;
    endcase
  end

  // Registered status pin
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      status_pin_o <= 1'b0;
    end else begin
      status_pin_o <= pin_next;
    end
  end

  // Trigger selection and wake
  ccr_trig_sel u_trig (
    .mclk_i         (mclk_i),
    .rst_n_i        (rst_n_reg),
    .trig_src_i     (pin_cfg_reg[`CCR_TRIG_SRC_BIT]),
    .soft_trig_i    (soft_trig_reg),
    .hw_trig_i      (hw_trig_i),
    .lp_enable_i    (lp_reg[`CCR_LP_EN_BIT]),
    .lowpower_trigger_mode_mode_i (lp_reg[`CCR_LOWPOWER_TRIGGER_MODE_BIT]),
    .trigger_o      (trigger_o),
    .wake_o         (wake_o)
  );

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_mask_reg;
  logic [3:0] events;
  logic       fg_prev_reg;
  logic       halt_prev_reg;
  logic       alarm_prev_reg;

  // Rising- and falling-edge history
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      fg_prev_reg    <= 1'b0;
      halt_prev_reg  <= 1'b0;
      alarm_prev_reg <= 1'b0;
    end else begin
      fg_prev_reg    <= foreground_done_reg;
      halt_prev_reg  <= halted_reg;
      alarm_prev_reg <= engine_i.alarm;
    end
  end

  // Events: done, halted, resumed, alarm
  assign events = {engine_i.alarm & ~alarm_prev_reg,
                   ~halted_reg & halt_prev_reg,
                   halted_reg & ~halt_prev_reg,
                   foreground_done_reg & ~fg_prev_reg};

  // Sticky status, set wins over clear
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      irq_stat_reg <= 4'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~(wr_irq_stat ? wdata_i[3:0] : 4'h0)) | events;
    end
  end

  // Interrupt mask
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      irq_mask_reg <= `CCR_RST_IRQ_MASK;
    end else if (wr_irq_mask) begin
      irq_mask_reg <= wdata_i[3:0];
    end
  end

  // Level interrupt
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // One-cycle read data, unmapped reads zero
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        `CCR_OFS_AVERAGING:  rdata_o <= {1'b0, offset_averaging_reg, 1'b0, lin_avg_reg};
        `CCR_OFS_STATUS:     rdata_o <= {3'h0, code_reg, halted_reg, foreground_done_reg};
        `CCR_OFS_PIN_CONFIG: rdata_o <= {5'h00, pin_cfg_reg};
        `CCR_OFS_SOFT_TRIG:  rdata_o <= {7'h00, soft_trig_reg};
        `CCR_OFS_LOW_POWER:  rdata_o <= lp_reg;
        `CCR_OFS_IRQ_STATUS: rdata_o <= {4'h0, irq_stat_reg};
        `CCR_OFS_IRQ_MASK:   rdata_o <= {4'h0, irq_mask_reg};
        default:             rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule

// ---- ccr_regs_props.sv ----
// Port-level checker for the calibration control bank
`timescale 1ns/1ns
`include "ccr_map.svh"
module ccr_regs_props
  import ccr_pkg::*;
(
  input wire logic          mclk_i,       // Clock
  input wire logic          rst_b_i,      // Async reset, active low
  input wire logic [7:0]    addr_i,       // Register address
  input wire logic [7:0]    wdata_i,      // Write data
  input wire logic          wr_i,         // Write strobe
  input wire logic          rd_i,         // Read strobe
  input wire logic [7:0]    rdata_o,      // Read data
  input wire ccr_engine_s   engine_i,     // Engine status
  input wire logic          hw_trig_i,    // Trigger pin
  input wire logic          status_pin_o, // Status pin
  input wire logic          trigger_o,    // Selected trigger
  input wire logic          wake_o,       // Wake request
  input wire ccr_settings_s settings_o    // Engine settings
);
  logic [2:0] sync_q;
  logic       rst_d;
  logic [7:0] avg_m;
  logic [7:0] cfg_m;
  logic [7:0] lp_m;
  logic       soft_m;
  // ----------------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------------
  // Reset copy, two stages behind the design's own so registered outputs settle
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_q <= 3'h0;
      rst_d  <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], 1'b1};
      rst_d  <= sync_q[2];
    end
  end
  // Shadows of the writable fields
  always_ff @(posedge mclk_i) begin
    if (!sync_q[1]) begin
      avg_m  <= 8'h61;
      cfg_m  <= 8'h00;
      lp_m   <= 8'h88;
      soft_m <= 1'b1;
    end else if (wr_i) begin
      case (addr_i)
        `CCR_OFS_AVERAGING:  avg_m  <= wdata_i & 8'h77;
        `CCR_OFS_PIN_CONFIG: cfg_m  <= wdata_i & 8'h07;
        `CCR_OFS_LOW_POWER:  lp_m   <= wdata_i;
        `CCR_OFS_SOFT_TRIG:  soft_m <= wdata_i[0];
        default: ;
      endcase
    end
  end
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_d);
  sequence halt_ev;
    engine_i.bg_stopped || (!engine_i.bg_enabled && engine_i.foreground_done);
  endsequence
  sequence resume_ev;
    engine_i.bg_resumed && !engine_i.bg_stopped && (engine_i.bg_enabled || !engine_i.foreground_done);
  endsequence
  a_read_stands: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its cycle");
  a_avg_read: assert property ($past(rd_i && addr_i == `CCR_OFS_AVERAGING) |-> rdata_o == avg_m)
    else $error("averaging read mismatch");
  a_settings_avg: assert property (settings_o.offset_averaging == $past(avg_m[6:4]) && settings_o.linearity_averaging == $past(avg_m[2:0]))
    else $error("averaging settings mismatch");
  a_settings_lp: assert property (settings_o.lp_enable == $past(lp_m[0]) &&
    settings_o.lowpower_trigger_mode == $past(lp_m[1]))
    else $error("low-power settings mismatch");
  a_trig_select: assert property (trigger_o == $past(cfg_m[0] ? hw_trig_i : soft_m))
    else $error("trigger source mismatch");
  a_pin_alarm: assert property ($past(cfg_m[2:1] == CCR_SEL_ALARM) |-> status_pin_o == $past(engine_i.alarm))
    else $error("pin not showing alarm");
  a_pin_low: assert property ($past(cfg_m[2:1] == CCR_SEL_LOW) |-> !status_pin_o)
    else $error("pin not held low");
  a_pin_done: assert property ($past(rst_d) && $past(cfg_m[2:1] == CCR_SEL_FOREGROUND_DONE) |-> status_pin_o == $past(engine_i.foreground_done, 2))
    else $error("pin not showing done flag");
  a_halt_set: assert property ((halt_ev ##1 cfg_m[2:1] == CCR_SEL_HALTED) |=> status_pin_o)
    else $error("halted flag not set");
  a_halt_clear: assert property ((resume_ev ##1 cfg_m[2:1] == CCR_SEL_HALTED) |=> !status_pin_o)
    else $error("halted flag not cleared");
  a_wake_off: assert property ($past(lp_m[1:0] != 2'h3) && $past(lp_m[1:0] != 2'h3, 2) |-> !wake_o)
    else $error("wake outside trigger mode");
endmodule

// ---- ccr_ext_ctrl.sv ----
// External controller model: drives the trigger pin, watches the status pin
`timescale 1ns/1ns
module ccr_ext_ctrl (
  input  wire logic mclk_i,       // Clock
  input  wire logic trig_req_i,   // Trigger level asked for
  input  wire logic slow_i,       // Answer one cycle late
  input  wire logic status_pin_i, // Status pin from the device
  output logic      hw_trig_o,    // Trigger pin to the device
  output logic      pin_seen_o    // Status pin as sampled
);
  logic req_q;
  // Pin starts high so nothing is requested at power-up
  initial hw_trig_o = 1'b1;
  // Pin driven after the edge, promptly or late
  always @(posedge mclk_i) begin
    req_q      <= trig_req_i;
    hw_trig_o  <= slow_i ? req_q : trig_req_i;
    pin_seen_o <= status_pin_i;
  end
endmodule

// ---- tb.sv ----
// Self-checking bench for the calibration control bank
`timescale 1ns/1ns
`include "ccr_map.svh"
module tb;
  import ccr_pkg::*;
  logic          mclk_i = 1'b0;
  logic          rst_b_i = 1'b0;
  logic [7:0]    addr_i = 8'h00;
  logic [7:0]    wdata_i = 8'h00;
  logic          wr_i = 1'b0;
  logic          rd_i = 1'b0;
  logic          trig_req = 1'b1;
  logic          slow = 1'b0;
  ccr_engine_s   eng = '0;
  logic [7:0]    rdata_o;
  logic          hw_trig, status_pin, pin_seen, trigger_o, wake_o, irq_o;
  ccr_settings_s settings_o;
  int            err_total = 0;
  int            n_tests = 0;
  int            cyc = 0;
  // ----------------------------------------------------------------------
  // Clock and instances
  // ----------------------------------------------------------------------
  always #4 mclk_i = ~mclk_i;
  ccr_regs i_dut (.mclk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .engine_i(eng), .hw_trig_i(hw_trig), .status_pin_o(status_pin), .trigger_o,
    .wake_o, .settings_o, .irq_o);
  ccr_ext_ctrl i_ext (.mclk_i, .trig_req_i(trig_req), .slow_i(slow),
    .status_pin_i(status_pin), .hw_trig_o(hw_trig), .pin_seen_o(pin_seen));
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk(n, rdata_o, e);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    rd("avg", `CCR_OFS_AVERAGING, 8'h61);
    rd("cfg", `CCR_OFS_PIN_CONFIG, 8'h00);
    rd("soft", `CCR_OFS_SOFT_TRIG, 8'h01);
    rd("lp", `CCR_OFS_LOW_POWER, 8'h88);
    rd("stat", `CCR_OFS_STATUS, 8'h00);
    rd("unmapped", 8'h40, 8'h00);
    chk("trig", 8'(trigger_o), 8'h01);
  endtask
  task automatic t_avg;
    wr(`CCR_OFS_AVERAGING, 8'hFF);
    rd("avg_rsv", `CCR_OFS_AVERAGING, 8'h77);
    chk("offset_averaging", 8'(settings_o.offset_averaging), 8'h07);
    wr(`CCR_OFS_AVERAGING, 8'h61);
  endtask
  task automatic t_status;
    wr(`CCR_OFS_PIN_CONFIG, 8'h02);
    @(posedge mclk_i);
    eng.code    <= 3'h5;
    eng.foreground_done <= 1'b1;
    wait_n(3);
    rd("stat_fg", `CCR_OFS_STATUS, 8'h17);
    chk("pin_fg", 8'(pin_seen), 8'h01);
    wr(`CCR_OFS_STATUS, 8'h00);
    rd("stat_ro", `CCR_OFS_STATUS, 8'h17);
    @(posedge mclk_i);
    eng.bg_enabled <= 1'b1;
    eng.bg_resumed <= 1'b1;
    @(posedge mclk_i);
    eng.bg_resumed <= 1'b0;
    wait_n(2);
    rd("stat_run", `CCR_OFS_STATUS, 8'h15);
    chk("pin_run", 8'(pin_seen), 8'h00);
    @(posedge mclk_i);
    eng.bg_stopped <= 1'b1;
    @(posedge mclk_i);
    eng.bg_stopped <= 1'b0;
    wait_n(2);
    rd("stat_stop", `CCR_OFS_STATUS, 8'h17);
    chk("pin_stop", 8'(pin_seen), 8'h01);
  endtask
  task automatic t_pin;
    @(posedge mclk_i);
    eng.alarm <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(`CCR_OFS_PIN_CONFIG, 8'(i << 1));
      wait_n(3);
      chk("pin", 8'(pin_seen), 8'(i != 3));
    end
    @(posedge mclk_i);
    eng.alarm <= 1'b0;
    wr(`CCR_OFS_PIN_CONFIG, 8'h04);
    wait_n(3);
    chk("pin_alarm", 8'(pin_seen), 8'h00);
  endtask
  task automatic t_trig;
    wr(`CCR_OFS_SOFT_TRIG, 8'h00);
    wait_n(3);
    chk("trig_sw", 8'(trigger_o), 8'h00);
    wr(`CCR_OFS_SOFT_TRIG, 8'h01);
    wr(`CCR_OFS_PIN_CONFIG, 8'h01);
    @(posedge mclk_i);
    trig_req <= 1'b0;
    slow     <= 1'b1;
    wait_n(4);
    chk("trig_hw", 8'(trigger_o), 8'h00);
    wr(`CCR_OFS_LOW_POWER, 8'h8B);
    wait_n(3);
    chk("wake_on", 8'(wake_o), 8'h01);
    @(posedge mclk_i);
    trig_req <= 1'b1;
    wait_n(5);
    chk("wake_off", 8'(wake_o), 8'h00);
    wr(`CCR_OFS_LOW_POWER, 8'h88);
    wr(`CCR_OFS_PIN_CONFIG, 8'h00);
    wait_n(3);
    chk("trig_idle", 8'(trigger_o), 8'h01);
  endtask
  task automatic t_irq;
    rd("irq_st", `CCR_OFS_IRQ_STATUS, 8'h0F);
    chk("irq_masked", 8'(irq_o), 8'h00);
    wr(`CCR_OFS_IRQ_MASK, 8'h0F);
    wait_n(2);
    chk("irq_on", 8'(irq_o), 8'h01);
    wr(`CCR_OFS_IRQ_STATUS, 8'h0F);
    wait_n(2);
    rd("irq_clr", `CCR_OFS_IRQ_STATUS, 8'h00);
    chk("irq_off", 8'(irq_o), 8'h00);
  endtask
  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    wait_n(3);
    t_reset;
    t_avg;
    t_status;
    t_pin;
    t_trig;
    t_irq;
    summarize();
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      summarize();
    end
  end
endmodule
bind ccr_regs ccr_regs_props i_props (.mclk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .engine_i, .hw_trig_i, .status_pin_o, .trigger_o, .wake_o, .settings_o);
